// [src/dcri_regs.sv]
`timescale 1ns/100ps
// Behaviour
// R1 - each local register has one copy per channel, picked by bits 0 and 1 of the index register.
// R2 - with both channel bits set, a local write lands in both channel copies.
// R3 - the host selects exactly one channel before reading a local register; the bench also reads 0x0010 with both channel bits set.
// R4 - a local read with both channel bits set returns the channel-one copy.
// R5 - global registers hold one setting shared by the whole device.
// R6 - global accesses ignore the index register.
// R7 - the host only touches mapped addresses and bits.
// R8 - the setup register mirrors its nibbles, reads 0x18 by default with fixed ones in bits 4:3.
// R9 - program register writes go to shadows and move to the active set on a transfer write.
// R10 - the host writes zero to open bits and never writes wholly open addresses.
// R11 - reset loads table defaults and selects MSB-first shifting.
// R12 - the identification registers read fixed codes and ignore writes.
module dcri_regs
   import dcri_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic sclk,
   input wire logic csb_n,
   input wire logic sdio_in,
   output logic sdio_out,
   output logic sdio_oe,
   output logic [7:0] ch1_active [NPROG],
   output logic [7:0] ch2_active [NPROG]
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic sclk_r, sclk_nxt;
   dcri_phase_t phase_r, phase_nxt;
   logic [3:0] bitcnt_r, bitcnt_nxt;
   logic [15:0] sreg_r, sreg_nxt;
   logic rd_r, rd_nxt;
   logic [12:0] addr_r, addr_nxt;
   logic [1:0] wlen_r, wlen_nxt;
   logic [1:0] bytecnt_r, bytecnt_nxt;
   logic lsb_r, lsb_nxt;
   logic [7:0] index_r, index_nxt;
   logic [7:0] tx_r, tx_nxt;
   logic sdio_out_r, sdio_out_nxt;
   logic sdio_oe_r, sdio_oe_nxt;
   logic [7:0] sh1_r [NPROG];
   logic [7:0] sh2_r [NPROG];
   logic [7:0] act1_r [NPROG];
   logic [7:0] act2_r [NPROG];
   logic [7:0] sh1_nxt [NPROG];
   logic [7:0] sh2_nxt [NPROG];
   logic [7:0] act1_nxt [NPROG];
   logic [7:0] act2_nxt [NPROG];

   // ----------------------------------------------------------------
   // read decode, used for the first byte and for each streamed byte
   // ----------------------------------------------------------------
   function automatic logic [7:0] read_value(input logic [12:0] a);
      logic [7:0] v;
      v = OPEN_READ;
      unique case (a)
         ADDR_PORT_SETUP: begin
            v = SETUP_FIXED;  // see R8
            v[SETUP_LSB_HI] = lsb_r;
            v[SETUP_LSB_LO] = lsb_r;
         end
         ADDR_PART_ID: v = PART_ID_CODE;  // see R12
         ADDR_GRADE_ID: v = GRADE_ID_CODE;  // see R12
         ADDR_CH_INDEX: v = index_r;
         ADDR_XFER: v = XFER_READ;  // transfer bit has already cleared itself
         default: begin
            for (int i = 0; i < NPROG; i++) begin
               if (a == PROG_ADDR[i]) begin
                  // channel two only when it alone is selected; globals always copy one
                  if (PROG_LOCAL[i] && index_r[CH2_BIT] && !index_r[CH1_BIT]) begin
                     v = sh2_r[i];  // see R1
                  end else begin
                     v = sh1_r[i];  // see R4, see R6
                  end
               end
            end
         end
      endcase
      return v;
   endfunction

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      logic rise;
      logic fall;
      logic [7:0] d;
      logic [12:0] a_step;
      logic soft_rst;
      rise = 1'b0;
      fall = 1'b0;
      d = 8'h00;
      a_step = 13'h0000;
      soft_rst = 1'b0;
      sclk_nxt = sclk;
      phase_nxt = phase_r;
      bitcnt_nxt = bitcnt_r;
      sreg_nxt = sreg_r;
      rd_nxt = rd_r;
      addr_nxt = addr_r;
      wlen_nxt = wlen_r;
      bytecnt_nxt = bytecnt_r;
      lsb_nxt = lsb_r;
      index_nxt = index_r;
      tx_nxt = tx_r;
      sdio_out_nxt = sdio_out_r;
      sdio_oe_nxt = sdio_oe_r;
      sh1_nxt = sh1_r;
      sh2_nxt = sh2_r;
      act1_nxt = act1_r;
      act2_nxt = act2_r;
      rise = !csb_n && sclk && !sclk_r;
      fall = !csb_n && !sclk && sclk_r;
      if (csb_n) begin
         // frame ends: release the pin and wait for a fresh instruction
         phase_nxt = DCRI_INSTR;
         bitcnt_nxt = 4'h0;
         bytecnt_nxt = 2'h0;
         sdio_oe_nxt = 1'b0;
      end else if (rise && phase_r != DCRI_DONE) begin
         if (lsb_r) begin
            sreg_nxt = {sdio_in, sreg_r[15:1]};
         end else begin
            sreg_nxt = {sreg_r[14:0], sdio_in};
         end
         bitcnt_nxt = bitcnt_r + 4'h1;
         if (phase_r == DCRI_INSTR && bitcnt_r == INSTR_LAST_BIT) begin
            rd_nxt = sreg_nxt[RW_BIT];
            wlen_nxt = sreg_nxt[WLEN_HI:WLEN_LO];
            addr_nxt = sreg_nxt[12:0];
            bitcnt_nxt = 4'h0;
            phase_nxt = DCRI_DATA;
            tx_nxt = read_value(sreg_nxt[12:0]);
         end else if (phase_r == DCRI_DATA && bitcnt_r == BYTE_LAST_BIT) begin
            d = lsb_r ? sreg_nxt[15:8] : sreg_nxt[7:0];
            // streaming walks up in LSB-first mode and down in MSB-first mode
            a_step = lsb_r ? addr_r + 13'h0001 : addr_r - 13'h0001;
            addr_nxt = a_step;
            bitcnt_nxt = 4'h0;
            bytecnt_nxt = bytecnt_r + 2'h1;
            if (wlen_r != WLEN_STREAM && bytecnt_r == wlen_r) begin
               phase_nxt = DCRI_DONE;
            end
            if (rd_r) begin
               tx_nxt = read_value(a_step);
            end else begin
               unique case (addr_r)
                  ADDR_PORT_SETUP: begin
                     lsb_nxt = d[SETUP_LSB_HI] | d[SETUP_LSB_LO];  // see R8
                     soft_rst = d[SETUP_SRST_HI] | d[SETUP_SRST_LO];  // see R8
                  end
                  ADDR_CH_INDEX: index_nxt = d;
                  ADDR_XFER: begin
                     if (d[XFER_BIT]) begin
                        act1_nxt = sh1_r;  // see R9
                        act2_nxt = sh2_r;  // see R9
                     end
                  end
                  default: begin
                     // identification and open addresses take no write
                     for (int i = 0; i < NPROG; i++) begin
                        if (addr_r == PROG_ADDR[i]) begin
                           if (!PROG_LOCAL[i] || index_r[CH1_BIT]) begin
                              sh1_nxt[i] = d;  // see R2, see R5, see R6
                           end
                           if (!PROG_LOCAL[i] || index_r[CH2_BIT]) begin
                              sh2_nxt[i] = d;  // see R1, see R2, see R5
                           end
                        end
                     end
                  end
               endcase
            end
         end
      end else if (fall && phase_r == DCRI_DATA && rd_r) begin
         sdio_out_nxt = lsb_r ? tx_r[bitcnt_r[2:0]] : tx_r[3'h7 - bitcnt_r[2:0]];
         sdio_oe_nxt = 1'b1;
      end else if (fall && phase_r == DCRI_DONE) begin
         sdio_oe_nxt = 1'b0;
      end
      // soft reset restores the register set but leaves the frame running
      if (srst || soft_rst) begin
         lsb_nxt = 1'b0;  // see R11
         index_nxt = INDEX_RESET;  // see R11
         for (int i = 0; i < NPROG; i++) begin
            sh1_nxt[i] = PROG_RESET[i];  // see R11
            sh2_nxt[i] = PROG_RESET[i];
            act1_nxt[i] = PROG_RESET[i];
            act2_nxt[i] = PROG_RESET[i];
         end
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         sclk_r <= 1'b0;
         phase_r <= DCRI_INSTR;
         bitcnt_r <= 4'h0;
         sreg_r <= 16'h0000;
         rd_r <= 1'b0;
         addr_r <= 13'h0000;
         wlen_r <= 2'h0;
         bytecnt_r <= 2'h0;
         tx_r <= 8'h00;
         sdio_out_r <= 1'b0;
         sdio_oe_r <= 1'b0;
      end else begin
         sclk_r <= sclk_nxt;
         phase_r <= phase_nxt;
         bitcnt_r <= bitcnt_nxt;
         sreg_r <= sreg_nxt;
         rd_r <= rd_nxt;
         addr_r <= addr_nxt;
         wlen_r <= wlen_nxt;
         bytecnt_r <= bytecnt_nxt;
         tx_r <= tx_nxt;
         sdio_out_r <= sdio_out_nxt;
         sdio_oe_r <= sdio_oe_nxt;
      end
      // register set has its reset folded into the next-state logic
      lsb_r <= lsb_nxt;
      index_r <= index_nxt;
      sh1_r <= sh1_nxt;
      sh2_r <= sh2_nxt;
      act1_r <= act1_nxt;
      act2_r <= act2_nxt;
   end

   assign sdio_out = sdio_out_r;
   assign sdio_oe = sdio_oe_r;
   assign ch1_active = act1_r;
   assign ch2_active = act2_r;

endmodule // dcri_regs

// [include/dcri_pkg.sv]
package dcri_pkg;

   // ----------------------------------------------------------------
   // register addresses
   // ----------------------------------------------------------------
   localparam logic [12:0] ADDR_PORT_SETUP = 13'h0000;
   localparam logic [12:0] ADDR_PART_ID = 13'h0001;
   localparam logic [12:0] ADDR_GRADE_ID = 13'h0002;
   localparam logic [12:0] ADDR_CH_INDEX = 13'h0005;
   localparam logic [12:0] ADDR_XFER = 13'h00ff;

   // ----------------------------------------------------------------
   // program registers: address, local flag, default
   // ----------------------------------------------------------------
   localparam int NPROG = 9;
   localparam logic [12:0] PROG_ADDR [NPROG] = '{13'h0008, 13'h0009, 13'h000d, 13'h000e,
      13'h000f, 13'h0010, 13'h0014, 13'h0016, 13'h0018};
   // bit i set: register i is duplicated per channel
   localparam logic [NPROG-1:0] PROG_LOCAL = 9'h07c;
   localparam logic [7:0] PROG_RESET [NPROG] = '{8'h00, 8'h09, 8'h00, 8'h00, 8'h02, 8'h00,
      8'h00, 8'h00, 8'h00};

   // ----------------------------------------------------------------
   // identification codes (values arbitrary)
   // ----------------------------------------------------------------
   localparam logic [7:0] PART_ID_CODE = 8'h5c;
   localparam logic [7:0] GRADE_ID_CODE = 8'h20;

   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int SETUP_LSB_HI = 6;
   localparam int SETUP_LSB_LO = 1;
   localparam int SETUP_SRST_HI = 5;
   localparam int SETUP_SRST_LO = 2;
   localparam logic [7:0] SETUP_FIXED = 8'h18;
   localparam int CH1_BIT = 0;
   localparam int CH2_BIT = 1;
   localparam logic [7:0] INDEX_RESET = 8'hff;
   localparam int XFER_BIT = 0;
   localparam logic [7:0] XFER_READ = 8'h00;
   localparam logic [7:0] OPEN_READ = 8'h00;

   // ----------------------------------------------------------------
   // serial frame layout
   // ----------------------------------------------------------------
   localparam logic [3:0] INSTR_LAST_BIT = 4'hf;
   localparam logic [3:0] BYTE_LAST_BIT = 4'h7;
   localparam int RW_BIT = 15;
   localparam int WLEN_HI = 14;
   localparam int WLEN_LO = 13;
   localparam logic [1:0] WLEN_STREAM = 2'h3;

   typedef enum {DCRI_INSTR, DCRI_DATA, DCRI_DONE} dcri_phase_t;

endpackage

// [verification/dcri_regs_sva.sv]
`timescale 1ns/100ps
module dcri_regs_sva
   import dcri_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic sclk,
   input wire logic csb_n,
   input wire logic sdio_in,
   input wire logic sdio_out,
   input wire logic sdio_oe,
   input wire logic [7:0] ch1_active [NPROG],
   input wire logic [7:0] ch2_active [NPROG]
);
   logic [8*NPROG-1:0] a1, a2, dflt;
   logic g_ok;
   always_comb begin
      g_ok = 1'b1;
      for (int i = 0; i < NPROG; i++) begin
         a1[8*i +: 8] = ch1_active[i];
         a2[8*i +: 8] = ch2_active[i];
         dflt[8*i +: 8] = PROG_RESET[i];
         if (!PROG_LOCAL[i] && ch1_active[i] != ch2_active[i]) g_ok = 1'b0;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   property p_rst_act; $past(srst) |-> a1 == dflt && a2 == dflt; endproperty
   a_rst_act: assert property (p_rst_act) else $error("active regs not default");
   property p_rst_pin; $past(srst) |-> !sdio_oe && !sdio_out; endproperty
   a_rst_pin: assert property (p_rst_pin) else $error("sdio driven after reset");
   property p_idle; csb_n && $past(csb_n) && !$past(srst) |-> $stable(a1) && $stable(a2);
   endproperty
   a_idle: assert property (p_idle) else $error("active regs moved outside frame");
   property p_xfer; ($changed(a1) || $changed(a2)) && !$past(srst)
      |-> !$past(csb_n) && ($past(sclk) || $past(sclk, 2)); endproperty
   a_xfer: assert property (p_xfer) else $error("active update off a data bit");
   property p_glob; g_ok; endproperty
   a_glob: assert property (p_glob) else $error("global copies differ");
   property p_oe_idle; csb_n && $past(csb_n) |-> !sdio_oe; endproperty
   a_oe_idle: assert property (p_oe_idle) else $error("sdio driven while deselected");
   property p_oe_rise; $rose(sdio_oe)
      |-> !$past(csb_n) && !$past(sclk) && ($past(sclk, 2) || $past(sclk, 3)); endproperty
   a_oe_rise: assert property (p_oe_rise) else $error("sdio enable off a falling sclk");
   property p_out; $changed(sdio_out) && !csb_n && !$past(csb_n) && !$past(srst)
      |-> !$past(sclk) && ($past(sclk, 2) || $past(sclk, 3)); endproperty
   a_out: assert property (p_out) else $error("read bit moved off a falling sclk");
   c_read: cover property ($rose(sdio_oe));
   c_xfer: cover property ($changed(a2));
   c_frame: cover property ($fell(csb_n));
endmodule // dcri_regs_sva
bind dcri_regs dcri_regs_sva u_sva (.clk(clk), .srst(srst), .sclk(sclk), .csb_n(csb_n),
   .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe), .ch1_active(ch1_active),
   .ch2_active(ch2_active));

// [verification/dcri_host.sv]
`timescale 1ns/100ps
module dcri_host (
   input wire logic clk,
   output logic sclk,
   output logic csb_n,
   output logic sdio_in,
   input wire logic sdio_out
);
   // set by the bench once the setup register has switched the shift order
   logic lsb_first = 1'b0;
   initial begin
      sclk = 1'b0;
      csb_n = 1'b1;
      sdio_in = 1'b0;
   end
   // ----
   // one bit: sclk low then high, two clk each, entered at a falling clk
   // ----
   task automatic bit_x(input logic drv, input logic b, output logic q);
      sclk = 1'b0;
      // released line toggles so stale data never passes for a read bit
      sdio_in = drv ? b : ~sdio_in;
      repeat (2) @(negedge clk);
      q = sdio_out;
      sclk = 1'b1;
      repeat (2) @(negedge clk);
   endtask
   // single byte frame, msb or lsb first, mapped places only
   task automatic frame(input logic rd, input logic [12:0] a, input logic [7:0] wd,
      output logic [7:0] rv);
      logic [15:0] ins;
      logic q;
      ins = {rd, 2'b00, a};
      @(negedge clk);
      csb_n = 1'b0;
      for (int i = 15; i >= 0; i--) bit_x(1'b1, ins[lsb_first ? 15 - i : i], q);
      for (int i = 7; i >= 0; i--) begin
         bit_x(!rd, wd[lsb_first ? 7 - i : i], q);
         rv[lsb_first ? 7 - i : i] = q;
      end
      csb_n = 1'b1;
      repeat (2) @(negedge clk);
   endtask
endmodule // dcri_host

// [verification/tb_dual_channel_register_index.sv]
`timescale 1ns/100ps
module tb_dual_channel_register_index
   import dcri_pkg::*;
;
   typedef struct {logic we; logic [12:0] a; logic [7:0] wd; logic [7:0] ex;} dcri_row_t;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic sclk, csb_n, sdio_in, sdio_out, sdio_oe;
   logic [7:0] ch1_active [NPROG];
   logic [7:0] ch2_active [NPROG];
   logic [7:0] rv;
   int n_fail = 0;
   int samples_checked = 0;
   // a single channel selected before local reads; only mapped places touched
   dcri_row_t rows [8] = '{
      '{1'b1, ADDR_CH_INDEX, 8'h02, 8'h02}, '{1'b1, 13'h000d, 8'h05, 8'h05},
      '{1'b1, ADDR_CH_INDEX, 8'h01, 8'h01}, '{1'b0, 13'h000d, 8'h00, 8'h00},
      '{1'b1, ADDR_PORT_SETUP, 8'h00, SETUP_FIXED}, '{1'b1, ADDR_PART_ID, 8'h33, PART_ID_CODE},
      '{1'b1, ADDR_GRADE_ID, 8'h00, GRADE_ID_CODE}, '{1'b0, ADDR_XFER, 8'h00, XFER_READ}};
   always #25 clk = ~clk;
   dcri_regs DUT (.clk(clk), .srst(srst), .sclk(sclk), .csb_n(csb_n), .sdio_in(sdio_in),
      .sdio_out(sdio_out), .sdio_oe(sdio_oe), .ch1_active(ch1_active), .ch2_active(ch2_active));
   dcri_host host (.clk(clk), .sclk(sclk), .csb_n(csb_n), .sdio_in(sdio_in),
      .sdio_out(sdio_out));
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         $display("[ERR] %s expected %h seen %h", nm, e, g);
         n_fail++;
      end
   endtask
   task automatic wr(input logic [12:0] a, input logic [7:0] d);
      host.frame(1'b0, a, d, rv);
   endtask
   task automatic rd(input logic [12:0] a);
      host.frame(1'b1, a, 8'h00, rv);
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // ----
   // main sequence
   // ----
   initial begin
      repeat (3) @(negedge clk);
      srst = 1'b0;
      for (int i = 0; i < NPROG; i++) begin
         chk("ch1 reset", PROG_RESET[i], ch1_active[i]);
         chk("ch2 reset", PROG_RESET[i], ch2_active[i]);
      end
      rd(ADDR_CH_INDEX);
      chk("index reset", INDEX_RESET, rv);
      foreach (rows[i]) begin
         if (rows[i].we) wr(rows[i].a, rows[i].wd);
         rd(rows[i].a);
         chk("row read", rows[i].ex, rv);
      end
      wr(ADDR_CH_INDEX, 8'h03);
      wr(13'h0010, 8'h07);
      chk("ch2 before xfer", 8'h00, ch2_active[5]);
      wr(ADDR_XFER, 8'h01);
      chk("ch1 both", 8'h07, ch1_active[5]);
      chk("ch2 both", 8'h07, ch2_active[5]);
      chk("ch1 local", 8'h00, ch1_active[2]);
      chk("ch2 local", 8'h05, ch2_active[2]);
      wr(ADDR_CH_INDEX, 8'h02);
      wr(13'h0010, 8'h06);
      wr(13'h0009, 8'h01);
      wr(ADDR_CH_INDEX, 8'h03);
      rd(13'h0010);
      chk("both read", 8'h07, rv);
      wr(ADDR_XFER, 8'h01);
      chk("ch1 kept", 8'h07, ch1_active[5]);
      chk("ch2 split", 8'h06, ch2_active[5]);
      chk("ch1 global", 8'h01, ch1_active[1]);
      wr(ADDR_PORT_SETUP, 8'h42);
      host.lsb_first = 1'b1;
      rd(ADDR_PORT_SETUP);
      chk("lsb setup", 8'h5a, rv);
      wr(13'h0010, 8'h0b);
      rd(13'h0010);
      chk("lsb local", 8'h0b, rv);
      wr(ADDR_PORT_SETUP, 8'h24);
      host.lsb_first = 1'b0;
      rd(ADDR_CH_INDEX);
      chk("soft reset index", INDEX_RESET, rv);
      chk("soft reset active", PROG_RESET[5], ch2_active[5]);
      wr(13'h0009, 8'h01);
      wr(ADDR_XFER, 8'h01);
      chk("global before reset", 8'h01, ch1_active[1]);
      @(negedge clk);
      srst = 1'b1;
      repeat (3) @(negedge clk);
      srst = 1'b0;
      chk("second reset", PROG_RESET[1], ch1_active[1]);
      wrap_up();
   end
   initial begin
      #2_000_000;
      n_fail++;
      wrap_up();
   end
endmodule // tb_dual_channel_register_index
